/* ldc_pkg.sv */
// Shared constants and types of the LED driver control registers.
// Assumes a single 20 MHz clock for the register bank and the timers.
package ldc_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ     = 20_000_000;
  localparam int unsigned DIM_HZ_0   = 220;
  localparam int unsigned DIM_HZ_1   = 250;
  localparam int unsigned DIM_HZ_2   = 280;
  localparam int unsigned DIM_HZ_3   = 330;
  localparam int unsigned STAGGER_US = 80;
  localparam int unsigned STAGGER_CYC = (CLK_HZ / 1_000_000) * STAGGER_US;
  localparam int unsigned RF_NUM     = 127500;
  localparam int unsigned RF_DEN     = 250;
  localparam int unsigned RF_FRAC    = 8;

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_DIM  = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h01;
  localparam logic [7:0] ADDR_RFLO = 8'h02;
  localparam logic [7:0] ADDR_RFHI = 8'h03;
  localparam logic [1:0] RST_DIM   = 2'h1;
  localparam logic [7:0] RST_CTRL  = 8'h40;
  localparam logic [1:0] RST_RFLO  = 2'h1;
  localparam logic [7:0] RST_RFHI  = 8'h6a;
  localparam int unsigned CTRL_PIN   = 7;
  localparam int unsigned CTRL_LATCH = 6;
  localparam int unsigned CTRL_STH   = 4;
  localparam int unsigned CTRL_SLEW  = 2;
  localparam int unsigned CTRL_STAG  = 1;
  localparam int unsigned CTRL_EN    = 0;
  localparam int unsigned NUM_CH     = 8;
  localparam int unsigned DUTY_W     = 12;
  localparam logic [3:0]  I2C_BITS   = 4'h8;

  // Register access from the serial port
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ldc_req_t;

  // Half refresh period per divisor unit, fixed point with RF_FRAC bits
  function automatic logic [15:0] ldc_rf_scale(input int unsigned hz);
    longint v;
    v = (longint'(CLK_HZ) * RF_DEN * (1 << (RF_FRAC - 1)))
        / (longint'(RF_NUM) * hz);
    return v[15:0];
  endfunction

endpackage

/* ldc_i2c_slave.sv */
// Serial register port: 7-bit addressed target with a byte pointer.
// Assumes SCL and SDA arrive asynchronously from the bus pins.
`timescale 1ns/100ps
`default_nettype none
module ldc_i2c_slave
  import ldc_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h30  // Arbitrary value
) (
  input  wire logic       i_clock,
  input  wire logic       i_rst,
  input  wire logic       i_clk_en,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  input  wire logic [7:0] i_rd_data,
  output logic            o_sda_oe,
  output logic [7:0]      o_rd_addr,
  output ldc_req_t        o_req
);

  typedef enum logic [8:0] {
    S_IDLE  = 9'h001, S_ADDR  = 9'h002, S_ACK_A = 9'h004,
    S_PTR   = 9'h008, S_ACK_P = 9'h010, S_WDATA = 9'h020,
    S_ACK_W = 9'h040, S_RDATA = 9'h080, S_RACK  = 9'h100
  } ldc_i2c_st_t;

  ldc_i2c_st_t st_q;
  logic [2:0]  scl_q;
  logic [2:0]  sda_q;
  logic [3:0]  cnt_q;
  logic [7:0]  sh_q;
  logic [7:0]  ptr_q;
  logic        rw_q;
  logic        nack_q;

  // ----------------------------------------------------------------
  // Pin synchronisers; stage 0 feeds only stage 1
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
    end else if (i_clk_en) begin
      scl_q <= {scl_q[1:0], i_scl};
      sda_q <= {sda_q[1:0], i_sda};
    end
  end

  // Bus events seen on the synchronised pins
  wire rise  = scl_q[1] & ~scl_q[2];
  wire fall  = ~scl_q[1] & scl_q[2];
  wire start = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
  wire stop  = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];
  wire full  = (cnt_q == I2C_BITS);
  wire [7:0] byte_in = {sh_q[6:0], sda_q[1]};
  assign o_rd_addr = ptr_q;

  // ----------------------------------------------------------------
  // Byte engine; data changes only after SCL falls
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      st_q <= S_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      ptr_q <= 8'h00;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
      o_sda_oe <= 1'b0;
      o_req <= '0;
    end else if (i_clk_en) begin
      o_req.wr <= 1'b0;
      o_req.rd <= 1'b0;
      if (start) begin
        st_q <= S_ADDR;
        cnt_q <= 4'h0;
        o_sda_oe <= 1'b0;
      end else if (stop) begin
        st_q <= S_IDLE;
        o_sda_oe <= 1'b0;
      end else begin
        case (st_q)
          S_ADDR, S_PTR, S_WDATA: begin
            if (rise && !full) begin
              sh_q <= byte_in;
              cnt_q <= cnt_q + 4'h1;
            end else if (fall && full) begin
              cnt_q <= 4'h0;
              o_sda_oe <= 1'b1;
              if (st_q == S_PTR) begin
                ptr_q <= sh_q;
                st_q <= S_ACK_P;
              end else if (st_q == S_WDATA) begin
                o_req.wr <= 1'b1;
                o_req.addr <= ptr_q;
                o_req.wdata <= sh_q;
                ptr_q <= ptr_q + 8'h01;
                st_q <= S_ACK_W;
              end else if (sh_q[7:1] == DEV_ADDR) begin
                rw_q <= sh_q[0];
                st_q <= S_ACK_A;
              end else begin
                o_sda_oe <= 1'b0;  // Not ours: wait for next start
                st_q <= S_IDLE;
              end
            end
          end
          S_ACK_A, S_RACK: begin
            if (rise) begin
              nack_q <= sda_q[1];
            end else if (fall) begin
              if (st_q == S_RACK && nack_q) begin
                o_sda_oe <= 1'b0;
                st_q <= S_IDLE;
              end else if (st_q == S_RACK || rw_q) begin
                sh_q <= i_rd_data;
                o_sda_oe <= ~i_rd_data[7];
                o_req.rd <= 1'b1;
                o_req.addr <= ptr_q;
                st_q <= S_RDATA;
              end else begin
                o_sda_oe <= 1'b0;
                st_q <= S_PTR;
              end
            end
          end
          S_ACK_P, S_ACK_W: begin
            if (fall) begin
              o_sda_oe <= 1'b0;
              st_q <= S_WDATA;
            end
          end
          S_RDATA: begin
            if (rise) begin
              cnt_q <= cnt_q + 4'h1;
            end else if (fall && full) begin
              cnt_q <= 4'h0;
              o_sda_oe <= 1'b0;
              ptr_q <= ptr_q + 8'h01;
              st_q <= S_RACK;
            end else if (fall) begin
              sh_q <= {sh_q[6:0], 1'b0};
              o_sda_oe <= ~sh_q[6];
            end
          end
          S_IDLE: st_q <= S_IDLE;
          default: st_q <= S_IDLE;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

/* ldc_top.sv */
// Global control registers of an eight-channel LED driver, with the
// dimming timer, phase stagger, refresh generator and fault handling.
// Assumes fault inputs are asynchronous analog flags; duty and channel
// enables come from per-channel logic on the same clock.
//
// Contract
// [RQ1] Dimming code 00..11 selects 220, 250, 280 or 330 Hz PWM rate.
// [RQ2] Host changes dimming code only while global enable is clear.
// [RQ3] Host waits 10 us after a dimming code write before others.
// [RQ4] Control bit 7 picks refresh (0) or fault indication (1) on pin.
// [RQ5] Control bit 6 picks latch-off (1) or hiccup retry (0) on fault.
// [RQ6] Bits 5:4 select short threshold 2, 3, 4 or 5 V; reset 00.
// [RQ7] Bits 3:2 select current ramp none, 5, 10 or 20 us; reset 00.
// [RQ8] Stagger bit set delays each channel's rising edge by 80 us.
// [RQ9] Sticky over-temperature flag reads at bit 2; resets to 0.
// [RQ10] Divisor low two bits in one register, upper eight next, 6A.
// [RQ11] Divisor zero holds the refresh output constantly high.
// [RQ12] Refresh rate is 127500 over divisor times dimming rate over 250.
// [RQ13] Low divisor bits take effect only when upper bits are written.
// [RQ14] Global enable resets 0; channels stay dark until it is set.
`timescale 1ns/100ps
`default_nettype none
module ldc_top
  import ldc_pkg::*;
#(
  parameter int unsigned DIM_PER_0 = CLK_HZ / DIM_HZ_0,
  parameter int unsigned DIM_PER_1 = CLK_HZ / DIM_HZ_1,
  parameter int unsigned DIM_PER_2 = CLK_HZ / DIM_HZ_2,
  parameter int unsigned DIM_PER_3 = CLK_HZ / DIM_HZ_3
) (
  input  wire logic                            i_clock,
  input  wire logic                            i_rst,
  input  wire logic                            i_clk_en,
  input  wire logic                            i_scl,
  input  wire logic                            i_sda,
  input  wire logic                            i_fault,
  input  wire logic                            i_overtemp,
  input  wire logic [NUM_CH-1:0]               i_chan_enable,
  input  wire logic [NUM_CH-1:0][DUTY_W-1:0]   i_duty,
  output logic                                 o_sda_oe,
  output logic [NUM_CH-1:0]                    o_led_channel_output,
  output logic                                 o_refresh_or_fault_pin,
  output logic [1:0]                           o_short_threshold_sel,
  output logic [1:0]                           o_slew_sel,
  output logic                                 o_latch_off
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  ldc_req_t    req;
  logic [7:0]  rd_addr;
  logic [7:0]  rd_data;
  logic [1:0]  dim_freq_sel_q;
  logic [7:0]  ctrl_q;
  logic [1:0]  rf_lo_shadow_q;
  logic [7:0]  rf_hi_q;
  logic [9:0]  refresh_divisor_q;
  logic        overtemp_flag_q;
  logic [1:0]  flt_sync_q;
  logic [1:0]  ot_sync_q;
  logic [16:0] dim_cnt_q;
  logic [17:0] rf_cnt_q;
  logic        rf_level_q;

  // ----------------------------------------------------------------
  // Serial register port
  // ----------------------------------------------------------------
  ldc_i2c_slave u_port (
    .i_clock   (i_clock),
    .i_rst     (i_rst),
    .i_clk_en  (i_clk_en),
    .i_scl     (i_scl),
    .i_sda     (i_sda),
    .i_rd_data (rd_data),
    .o_sda_oe  (o_sda_oe),
    .o_rd_addr (rd_addr),
    .o_req     (req)
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Write strobes per register and the read strobe of the low divisor register
  wire wr_dim  = req.wr && (req.addr == ADDR_DIM);
  wire wr_ctrl = req.wr && (req.addr == ADDR_CTRL);
  wire wr_rflo = req.wr && (req.addr == ADDR_RFLO);
  wire wr_rfhi = req.wr && (req.addr == ADDR_RFHI);
  wire rd_rflo = req.rd && (req.addr == ADDR_RFLO);

  // Control fields
  wire en_bit    = ctrl_q[CTRL_EN];
  wire stag_bit  = ctrl_q[CTRL_STAG];
  wire latch_bit = ctrl_q[CTRL_LATCH];
  wire pin_bit   = ctrl_q[CTRL_PIN];

  // Read data; reserved bits and unmapped pointers read as zero
  // [RQ9] flag readback
  assign rd_data =
    (rd_addr == ADDR_DIM)  ? {6'h00, dim_freq_sel_q} :
    (rd_addr == ADDR_CTRL) ? ctrl_q :
    (rd_addr == ADDR_RFLO) ? {5'h00, overtemp_flag_q, rf_lo_shadow_q} :
    (rd_addr == ADDR_RFHI) ? rf_hi_q : 8'h00;

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // The dimming code is applied at once; the host avoids glitches by
  // writing it only while disabled and pausing afterwards.
  // [RQ2] host keeps this
  // [RQ3] host keeps this
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      dim_freq_sel_q <= RST_DIM;
    end else if (i_clk_en && wr_dim) begin
      dim_freq_sel_q <= req.wdata[1:0];
    end
  end

  // [RQ14] enable resets clear
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      ctrl_q <= RST_CTRL;
    end else if (i_clk_en && wr_ctrl) begin
      ctrl_q <= req.wdata;
    end
  end

  // [RQ10] split divisor storage
  // [RQ13] load on upper write
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      rf_lo_shadow_q <= RST_RFLO;
      rf_hi_q <= RST_RFHI;
      refresh_divisor_q <= {RST_RFHI, RST_RFLO};
    end else if (i_clk_en) begin
      if (wr_rflo) begin
        rf_lo_shadow_q <= req.wdata[1:0];
      end
      if (wr_rfhi) begin
        rf_hi_q <= req.wdata;
        refresh_divisor_q <= {req.wdata, rf_lo_shadow_q};
      end
    end
  end

  // ----------------------------------------------------------------
  // Fault inputs and handling
  // ----------------------------------------------------------------
  // Fault pins are asynchronous; two stages before any use
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      flt_sync_q <= 2'h0;
      ot_sync_q <= 2'h0;
    end else if (i_clk_en) begin
      flt_sync_q <= {flt_sync_q[0], i_fault};
      ot_sync_q <= {ot_sync_q[0], i_overtemp};
    end
  end

  wire fault_now = flt_sync_q[1] | ot_sync_q[1];

  // Cleared by reading; a new event in the same cycle wins
  // [RQ9] sticky flag
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      overtemp_flag_q <= 1'b0;
    end else if (i_clk_en) begin
      overtemp_flag_q <= ot_sync_q[1] | (overtemp_flag_q & ~rd_rflo);
    end
  end

  // Latch-off holds until software clears the enable; hiccup mode
  // simply retries by following the fault level
  // [RQ5] latch or hiccup
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_latch_off <= 1'b0;
    end else if (i_clk_en) begin
      o_latch_off <= en_bit &
                     (o_latch_off | (fault_now & latch_bit));
    end
  end

  wire chan_block = ~en_bit | o_latch_off | fault_now;

  // ----------------------------------------------------------------
  // Dimming timer
  // ----------------------------------------------------------------
  // [RQ1] rate select
  wire [16:0] dim_per =
    (dim_freq_sel_q == 2'h0) ? DIM_PER_0[16:0] :
    (dim_freq_sel_q == 2'h1) ? DIM_PER_1[16:0] :
    (dim_freq_sel_q == 2'h2) ? DIM_PER_2[16:0] : DIM_PER_3[16:0];

  // Counter rests at zero while disabled so all channels restart
  // in phase when enabled
  // [RQ14] dimming held off
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      dim_cnt_q <= 17'h00000;
    end else if (i_clk_en) begin
      if (!en_bit || dim_cnt_q >= dim_per - 17'h00001) begin
        dim_cnt_q <= 17'h00000;
      end else begin
        dim_cnt_q <= dim_cnt_q + 17'h00001;
      end
    end
  end

  // Position in a channel's own period given its start offset.
  // Offsets must stay below the period, which holds for all rates.
  function automatic logic [16:0] phase_of(input logic [16:0] cnt,
                                           input logic [16:0] off,
                                           input logic [16:0] per);
    logic [17:0] s;
    s = (cnt >= off) ? {1'b0, cnt} - {1'b0, off}
                     : {1'b0, cnt} + {1'b0, per} - {1'b0, off};
    return s[16:0];
  endfunction

  logic [NUM_CH-1:0] led_d;

  // On-time is duty over 4096 of the period; the multiply costs area
  // but keeps every rate exact to one clock
  // [RQ8] 80 us stagger
  always_comb begin
    logic [16:0] off;
    logic [28:0] thr;
    off = 17'h00000;
    thr = 29'h00000000;
    for (int k = 0; k < NUM_CH; k++) begin
      off = stag_bit ? 17'(k * STAGGER_CYC) : 17'h00000;
      thr = 29'(i_duty[k] * dim_per);
      led_d[k] = ~chan_block & i_chan_enable[k] &
                 ({12'h000, phase_of(dim_cnt_q, off, dim_per)} <
                  thr[28:DUTY_W]);
    end
  end

  // [RQ14] outputs gated
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_led_channel_output <= '0;
    end else if (i_clk_en) begin
      o_led_channel_output <= led_d;
    end
  end

  // ----------------------------------------------------------------
  // Refresh generator
  // ----------------------------------------------------------------
  // Half period in cycles: divisor times a per-rate scale factor
  // [RQ12] refresh rate
  wire [15:0] rf_scale =
    (dim_freq_sel_q == 2'h0) ? ldc_rf_scale(DIM_HZ_0) :
    (dim_freq_sel_q == 2'h1) ? ldc_rf_scale(DIM_HZ_1) :
    (dim_freq_sel_q == 2'h2) ? ldc_rf_scale(DIM_HZ_2) :
                               ldc_rf_scale(DIM_HZ_3);
  wire [25:0] rf_prod = refresh_divisor_q * rf_scale;
  wire [17:0] rf_half = rf_prod[25:RF_FRAC];
  wire        rf_zero = (refresh_divisor_q == 10'h000);

  // [RQ11] zero gives high
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      rf_cnt_q <= 18'h00000;
      rf_level_q <= 1'b1;
    end else if (i_clk_en) begin
      if (rf_zero) begin
        rf_cnt_q <= 18'h00000;
        rf_level_q <= 1'b1;
      end else if (rf_cnt_q + 18'h00001 >= rf_half) begin
        rf_cnt_q <= 18'h00000;
        rf_level_q <= ~rf_level_q;
      end else begin
        rf_cnt_q <= rf_cnt_q + 18'h00001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Shared pin and analog settings
  // ----------------------------------------------------------------
  // Fault mode pulls the pin low while a fault is present or held
  // [RQ4] pin function
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_refresh_or_fault_pin <= 1'b1;
    end else if (i_clk_en) begin
      o_refresh_or_fault_pin <= pin_bit ?
        ~(fault_now | o_latch_off | overtemp_flag_q) : rf_level_q;
    end
  end

  // Analog side decodes the codes; kept registered for clean edges
  // [RQ6] short threshold
  // [RQ7] slew code
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_short_threshold_sel <= RST_CTRL[CTRL_STH +: 2];
      o_slew_sel <= RST_CTRL[CTRL_SLEW +: 2];
    end else if (i_clk_en) begin
      o_short_threshold_sel <= ctrl_q[CTRL_STH +: 2];
      o_slew_sel <= ctrl_q[CTRL_SLEW +: 2];
    end
  end

endmodule
`default_nettype wire

/* ldc_props.sv */
// Checker of the LED driver control block, bound to its top module.
// Assumes it sees the top ports only; register state stays hidden.
`timescale 1ns/100ps
`default_nettype none
module ldc_props
  import ldc_pkg::*;
(
  input wire logic                          i_clock,
  input wire logic                          i_rst,
  input wire logic                          i_clk_en,
  input wire logic                          i_scl,
  input wire logic                          i_sda,
  input wire logic                          i_fault,
  input wire logic                          i_overtemp,
  input wire logic [NUM_CH-1:0]             i_chan_enable,
  input wire logic [NUM_CH-1:0][DUTY_W-1:0] i_duty,
  input wire logic                          o_sda_oe,
  input wire logic [NUM_CH-1:0]             o_led_channel_output,
  input wire logic                          o_refresh_or_fault_pin,
  input wire logic [1:0]                    o_short_threshold_sel,
  input wire logic [1:0]                    o_slew_sel,
  input wire logic                          o_latch_off
);
  // ----------------------------------------------------------------
  // Port relations
  // ----------------------------------------------------------------
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // Reset values show on the first edge after release
  AST_RST_DARK: assert property ($fell(i_rst) |->
    o_led_channel_output == '0 && !o_latch_off && o_refresh_or_fault_pin)
    else $error("outputs not at reset level");
  AST_RST_FIELDS: assert property ($fell(i_rst) |->
    o_short_threshold_sel == 2'h0 && o_slew_sel == 2'h0)
    else $error("selects not at reset value");
  // Sync depth plus output flop is three edges, five leaves margin
  AST_FAULT_DARK: assert property (i_fault [*5] |->
    o_led_channel_output == '0) else $error("lit during fault");
  AST_LATCH_DARK: assert property (o_latch_off |->
    o_led_channel_output == '0) else $error("lit while latched");
  AST_LATCH_CAUSE: assert property ($rose(o_latch_off) |->
    $past(i_fault, 2) || $past(i_fault, 3) || $past(i_fault, 4))
    else $error("latch without fault");
  // Register driven outputs move only while a write is acknowledged
  AST_LATCH_CLEAR: assert property ($fell(o_latch_off) |->
    o_sda_oe) else $error("latch cleared without a write");
  AST_STH_WRITE: assert property (!$stable(o_short_threshold_sel) |->
    o_sda_oe) else $error("threshold moved without a write");
  AST_SLEW_WRITE: assert property (!$stable(o_slew_sel) |->
    o_sda_oe) else $error("slew moved without a write");
endmodule
bind ldc_top ldc_props i_props (.*);
`default_nettype wire

/* ldc_host.sv */
// Host model: I2C controller that reaches the register bank.
// Assumes the bench resolves SDA as a pulled-up open-drain wire.
`timescale 1ns/100ps
`default_nettype none
module ldc_host
  import ldc_pkg::*;
(
  input  wire logic       i_clock,
  input  wire logic       i_sda,
  output var  logic       o_scl,
  output var  logic       o_sda_low,
  output var  logic       o_rd_vld,
  output var  logic [7:0] o_rd_data
);
  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  int hc = 8; // Half SCL period in clocks; raised to act as a slow host
  // Idle bus: both lines released
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
    o_rd_vld = 1'b0;
    o_rd_data = 8'h00;
  end
  task automatic hw();
    repeat (hc) @(posedge i_clock);
  endtask
  // SDA moves one clock after SCL falls, never beside it
  task automatic sbit(input logic b, output logic s);
    @(posedge i_clock);
    o_sda_low <= !b;
    hw();
    o_scl <= 1'b1;
    hw();
    s = i_sda;
    o_scl <= 1'b0;
  endtask
  task automatic xbyte(input logic [7:0] tx, input logic ack,
                       output logic [7:0] rx);
    logic s;
    for (int i = 7; i >= 0; i--) sbit(tx[i], rx[i]);
    sbit(!ack, s);
  endtask
  task automatic start();
    @(posedge i_clock);
    o_sda_low <= 1'b0;
    hw();
    o_scl <= 1'b1;
    hw();
    o_sda_low <= 1'b1;
    hw();
    o_scl <= 1'b0;
  endtask
  task automatic stop();
    @(posedge i_clock);
    o_sda_low <= 1'b1;
    hw();
    o_scl <= 1'b1;
    hw();
    o_sda_low <= 1'b0;
    hw();
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    start();
    xbyte(8'h60, 1'b0, r);
    xbyte(a, 1'b0, r);
    xbyte(d, 1'b0, r);
    stop();
    if (a == ADDR_DIM) repeat (200) @(posedge i_clock);
  endtask
  // Pointer write, repeated start, one byte with a closing NACK
  task automatic rd(input logic [7:0] a);
    logic [7:0] r;
    start();
    xbyte(8'h60, 1'b0, r);
    xbyte(a, 1'b0, r);
    start();
    xbyte(8'h61, 1'b0, r);
    xbyte(8'hff, 1'b0, r);
    stop();
    o_rd_data <= r;
    o_rd_vld <= 1'b1;
    @(posedge i_clock);
    o_rd_vld <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* tb_led_driver_control_regs.sv */
// Testbench of the LED driver control registers over I2C.
// Assumes a 20 MHz clock and a pulled-up SDA shared with the host.
`timescale 1ns/100ps
`default_nettype none
module tb_led_driver_control_regs
  import ldc_pkg::*;
();
  // ----------------------------------------------------------------
  // Bench
  // ----------------------------------------------------------------
  localparam int P [4] = '{11600, 11500, 11400, 11300};
  logic i_clock, i_rst, i_clk_en, i_scl, i_fault, i_overtemp, o_sda_oe;
  logic o_refresh_or_fault_pin, o_latch_off, host_low, rd_vld;
  logic [NUM_CH-1:0]             i_chan_enable, o_led_channel_output;
  logic [NUM_CH-1:0][DUTY_W-1:0] i_duty;
  logic [1:0]                    o_short_threshold_sel, o_slew_sel;
  logic [7:0]                    rd_data;
  logic [1:0]                    led_q = '0;
  logic                          pin_q = 1'b0;
  logic [7:0]                    exp_q [$];
  wire  logic                    i_sda;
  int seed = 72359, miscompares = 0, checks_done = 0, cyc = 0;
  int r0_prev = 0, r0_last = 0, r1_last = 0, n_rise = 0;
  int p_prev = 0, p_last = 0, n_tog = 0;
  // Open drain with pull-up: low if either side pulls
  assign i_sda = !(host_low || o_sda_oe);
  ldc_top #(.DIM_PER_0(P[0]), .DIM_PER_1(P[1]), .DIM_PER_2(P[2]),
    .DIM_PER_3(P[3])) i_dut (.*);
  ldc_host i_host (.i_clock(i_clock), .i_sda(i_sda), .o_scl(i_scl),
    .o_sda_low(host_low), .o_rd_vld(rd_vld), .o_rd_data(rd_data));
  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end
  // Edge times of channels 0 and 1 and of the shared pin
  always @(posedge i_clock) begin
    cyc++;
    if (o_led_channel_output[0] && !led_q[0]) begin
      r0_prev = r0_last;
      r0_last = cyc;
      n_rise++;
    end
    if (o_led_channel_output[1] && !led_q[1]) r1_last = cyc;
    if (o_refresh_or_fault_pin !== pin_q) begin
      p_prev = p_last;
      p_last = cyc;
      n_tog++;
    end
    led_q = o_led_channel_output[1:0];
    pin_q = o_refresh_or_fault_pin;
  end
  // Each byte the host reads meets the oldest note
  always @(posedge i_clock) begin
    if (rd_vld === 1'b1) chk(16'(rd_data), 16'(exp_q.pop_front()), 0);
  end
  // A tolerance covers the refresh divider's rounding only
  task automatic chk(input logic [15:0] got, e, input int tol);
    checks_done++;
    if (tol == 0 ? got !== e : (got + tol < e || got > e + tol)) begin
      miscompares++;
      $display("MISMATCH %0t got %h exp %h", $time, got, e);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_host.rd(a);
  endtask
  task automatic await_n(ref int cnt, input int tgt);
    int k;
    k = 0;
    while (cnt < tgt && k < 30000) begin
      @(posedge i_clock);
      k++;
    end
    chk(16'(cnt >= tgt), 16'h1, 0);
  endtask
  task automatic meas_tog(input int div, input longint sc);
    await_n(n_tog, n_tog + 3);
    chk(16'(p_last - p_prev), 16'((div * sc) >> 8), 1);
  endtask
  task automatic pulse(input logic ot);
    if (ot) i_overtemp <= 1'b1;
    else i_fault <= 1'b1;
    repeat (10) @(posedge i_clock);
    i_overtemp <= 1'b0;
    i_fault <= 1'b0;
    repeat (5) @(posedge i_clock);
  endtask
  task automatic do_reset();
    i_rst <= 1'b1;
    repeat (10) @(posedge i_clock);
    i_rst <= 1'b0;
    repeat (3) @(posedge i_clock);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (95000) @(posedge i_clock);
    miscompares++;
    complete_run();
  end
  // Main sequence; second reset follows a control write
  initial begin
    logic [31:0] r;
    logic [7:0]  v;
    int          n0;
    longint      sc;
    i_clk_en <= 1'b1;
    i_fault <= 1'b0;
    i_overtemp <= 1'b0;
    r = $random(seed);
    i_chan_enable <= r[7:0] | 8'h03;
    for (int k = 0; k < NUM_CH; k++) begin
      r = $random(seed);
      i_duty[k] <= k < 2 ? 12'h800 : r[11:0];
    end
    do_reset();
    i_host.wr(8'h01, 8'hff);
    do_reset();
    rd(8'h00, 8'h01);
    rd(8'h01, 8'h40);
    rd(8'h02, 8'h01);
    rd(8'h03, 8'h6a);
    rd(8'h04, 8'h00);
    i_host.hc = 12;
    for (int i = 0; i < 4; i++) begin
      v = 8'h40 | 8'(i << 4) | 8'(i << 2);
      i_host.wr(8'h01, v);
      chk(16'(o_short_threshold_sel), 16'(i), 0);
      chk(16'(o_slew_sel), 16'(i), 0);
      rd(8'h01, v);
    end
    i_host.hc = 8;
    i_host.wr(8'h01, 8'hc0);
    chk(16'(o_refresh_or_fault_pin), 16'h1, 0);
    pulse(1'b1);
    chk(16'(o_refresh_or_fault_pin), 16'h0, 0);
    rd(8'h02, 8'h05);
    rd(8'h02, 8'h01);
    chk(16'(o_refresh_or_fault_pin), 16'h1, 0);
    i_host.wr(8'h01, 8'h41);
    pulse(1'b0);
    chk(16'(o_latch_off), 16'h1, 0);
    i_host.wr(8'h01, 8'h40);
    chk(16'(o_latch_off), 16'h0, 0);
    i_host.wr(8'h01, 8'h01);
    pulse(1'b0);
    chk(16'(o_latch_off), 16'h0, 0);
    for (int c = 0; c < 4; c++) begin
      i_host.wr(8'h01, 8'h40);
      chk(16'(o_led_channel_output), 16'h0, 0);
      i_host.wr(8'h00, 8'hfc | 8'(c));
      rd(8'h00, 8'(c));
      n0 = n_rise;
      i_host.wr(8'h01, c == 3 ? 8'h43 : 8'h41);
      await_n(n_rise, n0 + 2);
      chk(16'(r0_last - r0_prev), 16'(P[c]), 0);
    end
    chk(16'(r1_last - r0_prev), 16'(STAGGER_CYC), 0);
    sc = (longint'(CLK_HZ) * RF_DEN * 128) / (longint'(RF_NUM) * DIM_HZ_3);
    i_host.wr(8'h02, 8'h00);
    i_host.wr(8'h03, 8'h01);
    meas_tog(4, sc);
    i_host.wr(8'h02, 8'h03);
    rd(8'h02, 8'h03);
    meas_tog(4, sc);
    i_host.wr(8'h03, 8'h01);
    meas_tog(7, sc);
    i_host.wr(8'h02, 8'h00);
    i_host.wr(8'h03, 8'h00);
    n0 = n_tog;
    repeat (1000) @(posedge i_clock);
    chk(16'(n_tog - n0), 16'h0, 0);
    chk(16'(o_refresh_or_fault_pin), 16'h1, 0);
    complete_run();
  end
endmodule
`default_nettype wire
